// ==== rtl/dspc_chain.sv ====
`timescale 1ns/1ps
module dspc_chain
   import dspc_pkg::*;
(
   input  wire logic                    clk_sys,
   input  wire logic                    resetn,
   input  wire logic                    smp_valid,
   output logic                         smp_ready,
   input  wire logic signed [SMP_W-1:0] smp_data,
   input  wire dspc_cfg_s               cfg_i,
   output logic                         res_valid,
   output logic signed [VAL_W-1:0]      res_data,
   output logic                         path_volt,
   output logic [CNT_W-1:0]             fill_cnt
);

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [QW-1:0] abs48(input logic signed [QW-1:0] x);
      abs48 = x[QW-1] ? QW'(-x) : QW'(x);
   endfunction

   function automatic logic signed [VAL_W-1:0] sat_apply(input logic sgn,
                                                         input logic [QW-1:0] mag);
      if (mag > MAG_MAX)
         sat_apply = sgn ? VAL_NEG : VAL_POS;
      else if (sgn)
         sat_apply = -VAL_W'(mag);
      else
         sat_apply = VAL_W'(mag);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // declarations

   dspc_state_e             state_q;
   logic signed [VAL_W-1:0] smp_x;
   logic signed [VAL_W-1:0] prev_q;
   logic signed [VAL_W-1:0] acq_q;
   logic signed [VAL_W-1:0] acq_val;
   logic                    acq_ok;
   logic                    take;
   logic                    chg;
   logic [1:0]              win_q;
   dspc_mode_e              mode_q;
   logic [3:0]              units_q;
   logic [3:0]              range_q;
   logic [CNT_W-1:0]        win_len;
   logic signed [SUM_W-1:0] sum_q;
   logic [CNT_W-1:0]        cnt_q;
   logic [CNT_W-1:0]        ptr_q;
   logic signed [VAL_W-1:0] mem_q [MEM_D];
   logic signed [VAL_W-1:0] hi_q;
   logic signed [VAL_W-1:0] lo_q;
   logic signed [VAL_W-1:0] hi_n;
   logic signed [VAL_W-1:0] lo_n;
   logic                    pk_seed_q;
   logic                    in_pulse_q;
   logic signed [VAL_W-1:0] peak_q;
   logic signed [VAL_W-1:0] base_q;
   logic signed [VAL_W:0]   rise_d;
   logic                    rise;
   logic signed [VAL_W-1:0] val_q;
   logic                    sgn_q;
   logic signed [48:0]      prod;
   logic signed [48:0]      prod_sh;
   logic [VAL_W-1:0]        resp_sel;
   logic                    div_start;
   logic [QW-1:0]           div_num;
   logic [VAL_W-1:0]        div_den;
   logic                    div_done;
   logic [QW-1:0]           div_quot;

   ////////////////////////////////////////////////////////////////////////////
   // acquisition: cw sample, pulse energy or peak-to-peak span

   assign smp_x   = {{(VAL_W-SMP_W){smp_data[SMP_W-1]}}, smp_data};
   assign win_len = dspc_win_len(cfg_i.win_sel);
   // a settings change holds off new samples for the cycle the filter clears
   assign chg = (cfg_i.units != units_q) || (cfg_i.range != range_q) ||
                (cfg_i.mode != mode_q) || (cfg_i.win_sel != win_q);
   assign smp_ready = (state_q == ST_IDLE) && !chg;
   assign take      = smp_valid && smp_ready;
   assign rise_d    = {smp_x[VAL_W-1], smp_x} - {prev_q[VAL_W-1], prev_q};
   assign rise      = rise_d > $signed({9'h000, cfg_i.rise_thr});
   assign hi_n      = (!pk_seed_q || smp_x > hi_q) ? smp_x : hi_q;
   assign lo_n      = (!pk_seed_q || smp_x < lo_q) ? smp_x : lo_q;

   always_comb begin
      acq_ok  = 1'b0;
      acq_val = smp_x;
      case (cfg_i.mode)
         MODE_PKPK: begin
            acq_ok  = 1'b1;
            acq_val = hi_n - lo_n;
         end
         MODE_PULSE: begin
            // first falling sample ends the pulse; energy is peak minus baseline
            if (in_pulse_q && smp_x < peak_q) begin
               acq_ok  = 1'b1;
               acq_val = peak_q - base_q;
            end
         end
         default: acq_ok = 1'b1;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         win_q   <= 2'b00;
         mode_q  <= MODE_CW_CONT;
         units_q <= 4'h0;
         range_q <= 4'h0;
      end else begin
         win_q   <= cfg_i.win_sel;
         mode_q  <= cfg_i.mode;
         units_q <= cfg_i.units;
         range_q <= cfg_i.range;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prev_q     <= VAL_RST;
         hi_q       <= VAL_RST;
         lo_q       <= VAL_RST;
         pk_seed_q  <= 1'b0;
         in_pulse_q <= 1'b0;
         peak_q     <= VAL_RST;
         base_q     <= VAL_RST;
      end else if (chg) begin
         pk_seed_q  <= 1'b0;
         in_pulse_q <= 1'b0;
      end else if (take) begin
         prev_q <= smp_x;
         if (cfg_i.mode == MODE_PKPK) begin
            hi_q      <= hi_n;
            lo_q      <= lo_n;
            pk_seed_q <= 1'b1;
         end
         if (cfg_i.mode == MODE_PULSE) begin
            if (!in_pulse_q && rise) begin
               in_pulse_q <= 1'b1;
               base_q     <= prev_q;
               peak_q     <= smp_x;
            end else if (in_pulse_q) begin
               if (smp_x >= peak_q)
                  peak_q <= smp_x;
               else
                  in_pulse_q <= 1'b0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // moving average: running sum over a ring of the last N acquisitions

   always_ff @(posedge clk_sys) begin
      if (state_q == ST_FILT && cfg_i.filt_en)
         mem_q[ptr_q] <= acq_q;
   end

   // the ring wraps at the live window length; changing it clears the sum
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sum_q <= SUM_RST;
         cnt_q <= CNT_RST;
         ptr_q <= CNT_RST;
      end else if (chg) begin
         sum_q <= SUM_RST;
         cnt_q <= CNT_RST;
         ptr_q <= CNT_RST;
      end else if (state_q == ST_FILT && cfg_i.filt_en) begin
         if (cnt_q < win_len) begin
            sum_q <= sum_q + SUM_W'(acq_q);
            cnt_q <= cnt_q + 14'h0001;
         end else begin
            sum_q <= sum_q + SUM_W'(acq_q) - SUM_W'(mem_q[ptr_q]);
         end
         ptr_q <= (ptr_q == win_len - 14'h0001) ? CNT_RST : ptr_q + 14'h0001;
      end
   end

   assign fill_cnt = cnt_q;

   ////////////////////////////////////////////////////////////////////////////
   // shared divider for mean, responsivity and area

   // separate tables with and without the attenuator
   assign resp_sel = cfg_i.user_cal_sel ? cfg_i.user_cal :
                     (cfg_i.atten_on ? cfg_i.resp_att : cfg_i.resp_noatt);
   assign div_start = (state_q == ST_MEAN_S) || (state_q == ST_RESP_S) ||
                      (state_q == ST_AREA_S);

   always_comb begin
      case (state_q)
         ST_MEAN_S, ST_MEAN_W: begin
            div_num = abs48(QW'(sum_q));
            div_den = VAL_W'(cnt_q);
         end
         ST_RESP_S, ST_RESP_W: begin
            div_num = abs48(QW'(val_q)) << FRAC;
            div_den = resp_sel;
         end
         default: begin
            div_num = abs48(QW'(val_q)) << FRAC;
            div_den = cfg_i.area;
         end
      endcase
   end

   dspc_div u_div (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .start    (div_start),
      .dividend (div_num),
      .divisor  (div_den),
      .done     (div_done),
      .quot     (div_quot)
   );

   assign prod    = val_q * $signed({1'b0, cfg_i.gain});
   assign prod_sh = prod >>> GAIN_FRAC;

   ////////////////////////////////////////////////////////////////////////////
   // stage sequencer

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         acq_q   <= VAL_RST;
         val_q   <= VAL_RST;
         sgn_q   <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take && acq_ok) begin
                  acq_q   <= acq_val;
                  state_q <= ST_FILT;
               end
            end
            ST_FILT: begin
               val_q   <= acq_q;
               state_q <= cfg_i.filt_en ? ST_MEAN_S : ST_GAIN;
            end
            ST_MEAN_S: begin
               sgn_q   <= sum_q[SUM_W-1];
               state_q <= ST_MEAN_W;
            end
            ST_MEAN_W: begin
               if (div_done) begin
                  val_q   <= sat_apply(sgn_q, div_quot);
                  state_q <= ST_GAIN;
               end
            end
            ST_GAIN: begin
               val_q   <= sat_apply(prod_sh[48], abs48(QW'(prod_sh)));
               state_q <= ST_ZERO;
            end
            ST_ZERO: begin
               // zero subtraction wraps rather than saturates
               if (cfg_i.zero_en)
                  val_q <= val_q - cfg_i.zero_ref;
               if (cfg_i.units_sig)
                  state_q <= ST_OUT;
               else
                  state_q <= ST_RESP_S;
            end
            ST_RESP_S: begin
               sgn_q   <= val_q[VAL_W-1];
               state_q <= ST_RESP_W;
            end
            ST_RESP_W: begin
               if (div_done) begin
                  val_q   <= sat_apply(sgn_q, div_quot);
                  state_q <= cfg_i.per_area ? ST_AREA_S : ST_OUT;
               end
            end
            ST_AREA_S: begin
               sgn_q   <= val_q[VAL_W-1];
               state_q <= ST_AREA_W;
            end
            ST_AREA_W: begin
               if (div_done) begin
                  val_q   <= sat_apply(sgn_q, div_quot);
                  state_q <= ST_OUT;
               end
            end
            ST_OUT:  state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         res_valid <= 1'b0;
         res_data  <= VAL_RST;
      end else begin
         res_valid <= (state_q == ST_OUT);
         if (state_q == ST_OUT)
            res_data <= val_q;
      end
   end

   // path depends only on the responsivity units, never on single/continuous
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         path_volt <= 1'b0;
      else
         path_volt <= (cfg_i.resp_unit != RU_A_PER_W);
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   sequence s_rise;
      take && cfg_i.mode == MODE_PULSE && !in_pulse_q && rise && !chg;
   endsequence

   chk_clear_on_change: assert property (@(posedge clk_sys) disable iff (!resetn)
      chg |=> (cnt_q == CNT_RST) && (sum_q == SUM_RST))
      else $error("filter not cleared after settings change");

   chk_fill_limit: assert property (@(posedge clk_sys) disable iff (!resetn)
      !chg |-> cnt_q <= win_len)
      else $error("filter fill count beyond window length");

   chk_first_sample: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_q == ST_FILT && cfg_i.filt_en && cnt_q == CNT_RST && !chg)
      |=> cnt_q == 14'h0001 && sum_q == SUM_W'($past(acq_q)))
      else $error("first sample after clear not taken alone");

   chk_zero_sub: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_q == ST_ZERO) |=> val_q == ($past(cfg_i.zero_en) ?
         $past(val_q) - $past(cfg_i.zero_ref) : $past(val_q)))
      else $error("zero offset stage wrong");

   chk_unit_skip: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_q == ST_ZERO && cfg_i.units_sig) |=> state_q == ST_OUT ##1 res_valid)
      else $error("matching units did not bypass responsivity");

   chk_stage_order: assert property (@(posedge clk_sys) disable iff (!resetn)
      (state_q == ST_GAIN) |=> state_q == ST_ZERO)
      else $error("gain not followed by zero stage");

   chk_one_result: assert property (@(posedge clk_sys) disable iff (!resetn)
      res_valid |-> ($past(state_q) == ST_OUT) && (state_q == ST_IDLE) ##1 !res_valid)
      else $error("result pulse not tied to output stage");

   chk_path_sel: assert property (@(posedge clk_sys) disable iff (!resetn)
      ##1 path_volt == ($past(cfg_i.resp_unit) != RU_A_PER_W))
      else $error("input path does not follow responsivity units");

   chk_pulse_base: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_rise |=> in_pulse_q && base_q == $past(prev_q) && peak_q == $past(smp_x))
      else $error("baseline not captured at pulse rise");

   chk_pkpk_span: assert property (@(posedge clk_sys) disable iff (!resetn)
      (pk_seed_q && mode_q == MODE_PKPK) |-> hi_q >= lo_q)
      else $error("peak-to-peak maximum below minimum");

endmodule // dspc_chain

// ==== rtl/dspc_div.sv ====
`timescale 1ns/1ps
// restoring divider, one quotient bit per clock; divisor must hold until done
module dspc_div
   import dspc_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             resetn,
   input  wire logic             start,
   input  wire logic [QW-1:0]    dividend,
   input  wire logic [VAL_W-1:0] divisor,
   output logic                  done,
   output logic [QW-1:0]         quot
);

   logic [VAL_W:0] rem_q;
   logic [VAL_W:0] trial;
   logic [5:0]     step_q;
   logic           busy_q;

   assign trial = {rem_q[VAL_W-1:0], quot[QW-1]};

   // a zero divisor yields an all-ones quotient, which later saturates
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rem_q  <= 33'h0_0000_0000;
         quot   <= 48'h0000_0000_0000;
         step_q <= 6'h00;
         busy_q <= 1'b0;
         done   <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start) begin
            rem_q  <= 33'h0_0000_0000;
            quot   <= dividend;
            step_q <= DIV_STEPS;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            if (trial >= {1'b0, divisor}) begin
               rem_q <= trial - {1'b0, divisor};
               quot  <= {quot[QW-2:0], 1'b1};
            end else begin
               rem_q <= trial;
               quot  <= {quot[QW-2:0], 1'b0};
            end
            step_q <= step_q - 6'h01;
            if (step_q == 6'h01) begin
               busy_q <= 1'b0;
               done   <= 1'b1;
            end
         end
      end
   end

endmodule // dspc_div

// ==== rtl/dspc_pkg.sv ====
// Function
// - with filtering on, output the mean of the last N samples, N in 10/100/1000/10000
// - the window length is a live setting that may change during operation
// - before N samples arrive after a clear, output the mean of all received
// - clear the filter at power-up and on units, range or mode change
// - single-acquisition mode averages the last N acquisitions whatever their age
// - multiply each value by the configured input amplifier gain
// - subtract the zero reference while zeroing is on, else pass unchanged
// - divide by the wavelength responsivity, or by the user calibration value if selected
// - use a separate responsivity table when the attenuator is on
// - skip responsivity when display units equal detector signal units
// - per-area display units divide the value by the detector active area; skipped here with responsivity when units_sig is set
// - amp/watt detectors take the current path, volt/watt or volt/joule the voltage path
// - path choice ignores single versus continuous measurement
// - pulse energy is peak minus the level just before the sharp rise
// - the captured baseline may be negative, left by earlier pulses
// - peak-to-peak mode tracks maximum and minimum and reports the difference
package dspc_pkg;

   localparam int SMP_W     = 24;
   localparam int VAL_W     = 32;
   localparam int QW        = 48;
   localparam int CNT_W     = 14;
   localparam int SUM_W     = VAL_W + CNT_W;
   localparam int MEM_D     = 10000;
   localparam int FRAC      = 16;
   localparam int GAIN_FRAC = 8;

   localparam logic [5:0]       DIV_STEPS = 6'h30;
   localparam logic [CNT_W-1:0] WIN_LEN_0 = 14'h000a;
   localparam logic [CNT_W-1:0] WIN_LEN_1 = 14'h0064;
   localparam logic [CNT_W-1:0] WIN_LEN_2 = 14'h03e8;
   localparam logic [CNT_W-1:0] WIN_LEN_3 = 14'h2710;
   localparam logic [CNT_W-1:0] CNT_RST   = 14'h0000;
   localparam logic [SUM_W-1:0] SUM_RST   = 46'h0000_0000_0000;
   localparam logic [VAL_W-1:0] VAL_RST   = 32'h0000_0000;
   localparam logic [VAL_W-1:0] VAL_POS   = 32'h7fff_ffff;
   localparam logic [VAL_W-1:0] VAL_NEG   = 32'h8000_0000;
   localparam logic [QW-1:0]    MAG_MAX   = 48'h0000_7fff_ffff;

   typedef enum logic [1:0] {
      MODE_CW_CONT   = 2'b00,
      MODE_CW_SINGLE = 2'b01,
      MODE_PULSE     = 2'b10,
      MODE_PKPK      = 2'b11
   } dspc_mode_e;

   typedef enum logic [1:0] {
      RU_A_PER_W = 2'b00,
      RU_V_PER_W = 2'b01,
      RU_V_PER_J = 2'b10,
      RU_RSVD    = 2'b11
   } dspc_resp_unit_e;

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_FILT   = 4'b0001,
      ST_MEAN_S = 4'b0010,
      ST_MEAN_W = 4'b0011,
      ST_GAIN   = 4'b0100,
      ST_ZERO   = 4'b0101,
      ST_RESP_S = 4'b0110,
      ST_RESP_W = 4'b0111,
      ST_AREA_S = 4'b1000,
      ST_AREA_W = 4'b1001,
      ST_OUT    = 4'b1010
   } dspc_state_e;

   typedef struct packed {
      logic                   filt_en;
      logic [1:0]             win_sel;
      dspc_mode_e             mode;
      logic [3:0]             units;
      logic [3:0]             range;
      dspc_resp_unit_e        resp_unit;
      logic [15:0]            gain;
      logic                   zero_en;
      logic signed [VAL_W-1:0] zero_ref;
      logic                   units_sig;
      logic                   user_cal_sel;
      logic [VAL_W-1:0]       user_cal;
      logic                   atten_on;
      logic [VAL_W-1:0]       resp_noatt;
      logic [VAL_W-1:0]       resp_att;
      logic                   per_area;
      logic [VAL_W-1:0]       area;
      logic [SMP_W-1:0]       rise_thr;
   } dspc_cfg_s;

   function automatic logic [CNT_W-1:0] dspc_win_len(input logic [1:0] sel);
      case (sel)
         2'b00:   dspc_win_len = WIN_LEN_0;
         2'b01:   dspc_win_len = WIN_LEN_1;
         2'b10:   dspc_win_len = WIN_LEN_2;
         default: dspc_win_len = WIN_LEN_3;
      endcase
   endfunction

endpackage

// ==== testbench/dspc_adc_model.sv ====
`timescale 1ns/1ps
module dspc_adc_model
   import dspc_pkg::*;
(
   input  wire logic               clk_sys,
   input  wire logic               smp_ready,
   output logic                    smp_valid,
   output logic signed [SMP_W-1:0] smp_data,
   output logic                    stuck
);
   initial begin
      smp_valid = 1'b0;
      smp_data  = 24'h00_0000;
      stuck     = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // a sample stands until the edge that takes it; afterwards the line shows
   // its inverse so that a stale value can never pass for a fresh one
   task automatic send(input logic signed [SMP_W-1:0] v);
      int n;
      n = 0;
      @(negedge clk_sys);
      smp_valid = 1'b1;
      smp_data  = v;
      @(posedge clk_sys);
      while (smp_ready !== 1'b1 && n < 400) begin
         n++;
         @(posedge clk_sys);
      end
      if (n >= 400) stuck = 1'b1;
      @(negedge clk_sys);
      smp_valid = 1'b0;
      smp_data  = ~v;
   endtask
endmodule // dspc_adc_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; $display("BAD t=%0t got %h exp %h", $time, (a), (e)); end end
module testbench
   import dspc_pkg::*;
();
   logic                    clk_sys;
   logic                    resetn;
   logic                    smp_valid;
   logic                    smp_ready;
   logic signed [SMP_W-1:0] smp_data;
   dspc_cfg_s               cfg;
   logic                    res_valid;
   logic signed [VAL_W-1:0] res_data;
   logic                    path_volt;
   logic [CNT_W-1:0]        fill_cnt;
   logic                    stuck;
   int                      failures = 0;
   int                      cmp_count = 0;
   int                      cycles = 0;

   dspc_chain dut (.clk_sys(clk_sys), .resetn(resetn), .smp_valid(smp_valid),
      .smp_ready(smp_ready), .smp_data(smp_data), .cfg_i(cfg), .res_valid(res_valid),
      .res_data(res_data), .path_volt(path_volt), .fill_cnt(fill_cnt));
   dspc_adc_model adc (.clk_sys(clk_sys), .smp_ready(smp_ready), .smp_valid(smp_valid),
      .smp_data(smp_data), .stuck(stuck));

   initial clk_sys = 1'b0;
   always #12.5 clk_sys = ~clk_sys;

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      if (stuck === 1'b1) failures++;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // a run still going after 30000 cycles is failed here rather than stalling forever
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         give_verdict();
      end
   end

   task automatic run(input logic signed [SMP_W-1:0] v, input logic signed [VAL_W-1:0] e);
      int n;
      n = 0;
      adc.send(v);
      `CHK(smp_ready, 1'b0)
      while (res_valid !== 1'b1 && n < 400) begin
         n++;
         @(negedge clk_sys);
      end
      // a result that never comes counts against the run
      if (n >= 400) failures++;
      `CHK(res_data, e)
      `CHK(smp_ready, 1'b1)
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      resetn        = 1'b0;
      cfg           = '0;
      cfg.gain      = 16'h0100;
      cfg.units_sig = 1'b1;
      repeat (16) @(posedge clk_sys);
      @(negedge clk_sys);
      resetn = 1'b1;
      repeat (2) @(negedge clk_sys);
      run(24'h00_0064, 32'h0000_0064);
      cfg.gain = 16'h0200;
      run(24'h00_0064, 32'h0000_00c8);
      cfg.zero_en  = 1'b1;
      cfg.zero_ref = 32'h0000_0032;
      run(24'h00_0064, 32'h0000_0096);
      cfg.units_sig  = 1'b0;
      cfg.resp_noatt = 32'h0002_0000;
      run(24'h00_0064, 32'h0000_004b);
      cfg.atten_on = 1'b1;
      cfg.resp_att = 32'h0003_0000;
      run(24'h00_0064, 32'h0000_0032);
      cfg.user_cal_sel = 1'b1;
      cfg.user_cal     = 32'h0005_0000;
      run(24'h00_0064, 32'h0000_001e);
      cfg.per_area = 1'b1;
      cfg.area     = 32'h0002_0000;
      run(24'h00_0064, 32'h0000_000f);
      cfg.zero_en = 1'b0;
      run(24'hff_ff9c, 32'hffff_ffec);
      // path choice for each detector kind, in both measurement modes
      for (int m = 0; m < 2; m++) begin
         for (int ru = 0; ru < 3; ru++) begin
            cfg.mode      = dspc_mode_e'(m);
            cfg.resp_unit = dspc_resp_unit_e'(ru);
            repeat (3) @(negedge clk_sys);
            `CHK(path_volt, (ru != 0))
         end
      end
      cfg           = '0;
      cfg.gain      = 16'h0100;
      cfg.units_sig = 1'b1;
      cfg.filt_en   = 1'b1;
      cfg.range     = 4'h1;
      for (int k = 1; k <= 12; k++) begin
         run(SMP_W'(k), VAL_W'(k <= 10 ? (k + 1) / 2 : (2 * k - 9) / 2));
         `CHK(fill_cnt, CNT_W'(k < 10 ? k : 10))
      end
      // a window change mid-run restarts the average
      cfg.win_sel = 2'b01;
      run(24'h00_0028, 32'h0000_0028);
      `CHK(fill_cnt, 14'h0001)
      cfg.mode = MODE_CW_SINGLE;
      run(24'h00_0008, 32'h0000_0008);
      repeat (60) @(negedge clk_sys);
      run(24'h00_0004, 32'h0000_0006);
      cfg.filt_en  = 1'b0;
      cfg.mode     = MODE_PULSE;
      cfg.rise_thr = 24'h00_0032;
      adc.send(24'h00_0000);
      adc.send(24'hff_fffb);
      adc.send(24'h00_0064);
      adc.send(24'h00_0078);
      run(24'h00_006e, 32'h0000_007d);
      cfg.mode = MODE_PKPK;
      run(24'h00_000a, 32'h0000_0000);
      run(24'h00_001e, 32'h0000_0014);
      run(24'h00_0005, 32'h0000_0019);
      give_verdict();
   end
endmodule // testbench
